// ### core/nvp_pkg.sv
/*
  Constants and carrier types for the nonvolatile program/erase control block.
  Assumes an AXI4-Lite master with 12-bit byte addresses and a single 20 MHz clock.
*/
package nvp_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_MCR = 10'h0F0;
  localparam logic [9:0] IDX_PROT = 10'h0F1;
  localparam logic [9:0] IDX_DIV = 10'h0F2;
  localparam logic [9:0] IDX_PROG = 10'h0F3;
  localparam logic [11:0] ADR_MCR = {IDX_MCR, 2'b00};
  localparam logic [11:0] ADR_PROT = {IDX_PROT, 2'b00};
  localparam logic [11:0] ADR_DIV = {IDX_DIV, 2'b00};
  localparam logic [11:0] ADR_PROG = {IDX_PROG, 2'b00};

  // module configuration bit positions
  localparam int MCR_DLD = 7;
  localparam int MCR_SHD = 6;
  localparam int MCR_FO = 4;
  localparam int MCR_WS = 2;
  localparam int MCR_PL = 1;
  localparam int MCR_DMY = 0;
  localparam logic [3:0] MCR_RST_LO = 4'hC;

  // program control bit positions
  localparam int PRG_BULK_PROTECT = 7;
  localparam int PRG_AUTO = 5;
  localparam int PRG_BYTE = 4;
  localparam int PRG_ROW = 3;
  localparam int PRG_ERASE = 2;
  localparam int PRG_LAT = 1;
  localparam int PRG_PGM = 0;
  localparam logic [7:0] PROG_RST = 8'h80;

  // block protect register: bit 5 shadow protect, bits 4:0 blocks
  localparam int PROT_SH = 5;
  localparam logic [5:0] PROT_RST = 6'h3F;

  // array offsets inside the 1K window
  localparam logic [9:0] BLK3_BASE = 10'h200;
  localparam logic [9:0] BLK2_BASE = 10'h300;
  localparam logic [9:0] BLK1_BASE = 10'h380;
  localparam logic [9:0] BLK0_BASE = 10'h3C0;
  localparam logic [9:0] SHADOW_ADR = 10'h3C0;

  // timed cycle, counted in self-time ticks
  localparam int PGM_TIME_US = 10000;
  localparam int TICK_US = 35;
  localparam logic [8:0] PGM_TICKS = 9'((PGM_TIME_US + TICK_US - 1) / TICK_US);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_HOLD = 3'h4
  } nvp_state_t;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } nvp_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } nvp_axi_rsp_t;

  typedef struct packed {
    logic wr;
    logic [9:0] addr;
    logic [15:0] data;
    logic word;
  } nvp_arr_wr_t;

  typedef struct packed {
    logic hv_on;
    logic erase;
    logic byte_sel;
    logic row_sel;
    logic bulk_shadow;
    logic shadow_tgt;
    logic [9:0] addr;
    logic [15:0] data;
    logic word;
  } nvp_nv_op_t;
endpackage

// ### core/nvp_tick.sv
/*
  Self-time tick generator: divides the clock by the divider value.
  Assumes div is stable while run is high; no tick while div is zero.
*/
`timescale 1ns/100ps
module nvp_tick (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [9:0] div,
  // one-cycle tick
  output logic tick
);
  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } nvp_tick_st_t;

  nvp_tick_st_t s_ff;
  nvp_tick_st_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (!run || div == 10'h000) begin
      nxt_s.cnt = 10'h000;
    end else if (s_ff.cnt >= div - 10'h001) begin
      nxt_s.cnt = 10'h000;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;
endmodule

// ### core/nvp_ctrl.sv
/*
  Program/erase control for a byte-wide nonvolatile array: configuration,
  protection, divider and program control registers behind AXI4-Lite,
  plus the timed program/erase sequencer.
  Assumes mode, wait and array-bus inputs come from logic on clk, and the
  shadow word is valid while rst_b is low.
*/
`timescale 1ns/100ps
module nvp_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire nvp_pkg::nvp_axi_req_t axi_req,
  output nvp_pkg::nvp_axi_rsp_t axi_rsp,
  // chip state
  input wire logic special_mode_n,
  input wire logic wait_mode,
  input wire logic [15:0] shadow_word,
  // array bus
  input wire nvp_pkg::nvp_arr_wr_t arr_wr,
  input wire logic [9:0] rd_addr,
  output logic rd_shadow_sel,
  // array operation
  output nvp_pkg::nvp_nv_op_t nv_op,
  // configuration outputs
  output logic debug_lockout_disable,
  output logic flash_open,
  output logic clk_stop
);
  typedef struct packed {
    nvp_pkg::nvp_state_t st;
    logic [7:0] mcr;
    logic [7:0] prog;
    logic [9:0] div;
    logic [5:0] prot;
    logic div_once;
    logic lock_once;
    logic [9:0] la;
    logic [15:0] ld;
    logic lw;
    logic [8:0] tcnt;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } nvp_ctrl_st_t;

  nvp_ctrl_st_t s_ff;
  nvp_ctrl_st_t nxt_s;
  logic tick;
  logic special;
  logic wr_go;
  logic rd_go;
  logic [7:0] wd0;
  logic [7:0] wd1;
  logic [3:0] rsel;
  logic [3:0] wsel;

  // shadow word occupies the first two bytes of the top block
  function automatic logic is_shadow(input logic [9:0] a);
    is_shadow = (a[9:1] == nvp_pkg::SHADOW_ADR[9:1]);
  endfunction

  function automatic logic [2:0] blk_of(input logic [9:0] a);
    if (a < nvp_pkg::BLK3_BASE) begin
      blk_of = 3'h4;
    end else if (a < nvp_pkg::BLK2_BASE) begin
      blk_of = 3'h3;
    end else if (a < nvp_pkg::BLK1_BASE) begin
      blk_of = 3'h2;
    end else if (a < nvp_pkg::BLK0_BASE) begin
      blk_of = 3'h1;
    end else begin
      blk_of = 3'h0;
    end
  endfunction

  // one decode for both paths keeps read and write maps identical
  function automatic logic [3:0] reg_dec(input logic [11:0] a);
    if (a == nvp_pkg::ADR_MCR) begin
      reg_dec = 4'h1;
    end else if (a == nvp_pkg::ADR_PROT) begin
      reg_dec = 4'h2;
    end else if (a == nvp_pkg::ADR_DIV) begin
      reg_dec = 4'h4;
    end else if (a == nvp_pkg::ADR_PROG) begin
      reg_dec = 4'h8;
    end else begin
      reg_dec = 4'h0;
    end
  endfunction

  // true when the latched operation touches protected storage
  function automatic logic prot_hit(input nvp_ctrl_st_t s);
    logic shd_on;
    logic bulk_or_row;
    shd_on = !s.mcr[nvp_pkg::MCR_SHD];
    bulk_or_row = s.prog[nvp_pkg::PRG_ERASE] && !s.prog[nvp_pkg::PRG_BYTE];
    if (bulk_or_row && s.prog[nvp_pkg::PRG_BULK_PROTECT]) begin
      prot_hit = 1'b1;
    end else if (bulk_or_row && !s.prog[nvp_pkg::PRG_ROW]) begin
      prot_hit = (|s.prot[4:0]) || (shd_on && s.prot[nvp_pkg::PROT_SH]);
    end else if (shd_on && is_shadow(s.la) && !bulk_or_row) begin
      prot_hit = s.prot[nvp_pkg::PROT_SH];
    end else begin
      prot_hit = s.prot[blk_of(s.la)];
    end
  endfunction

  assign special = !special_mode_n;
  assign wr_go = axi_req.awvalid && axi_req.wvalid && !s_ff.bvalid;
  assign rd_go = axi_req.arvalid && !s_ff.rvalid;
  assign wd0 = axi_req.wdata[7:0];
  assign wd1 = axi_req.wdata[15:8];
  assign rsel = reg_dec(axi_req.araddr);
  assign wsel = reg_dec(axi_req.awaddr);

  always_comb begin
    nxt_s = s_ff;
    if (s_ff.bvalid && axi_req.bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.rvalid && axi_req.rready) begin
      nxt_s.rvalid = 1'b0;
    end

    // reads show live state, bit 3 of config always one
    if (rd_go) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = nvp_pkg::RESP_OKAY;
      nxt_s.rdata = 32'h0000_0000;
      if (rsel[0]) begin
        nxt_s.rdata[7:0] = s_ff.mcr;
      end else if (rsel[1]) begin
        nxt_s.rdata[5:0] = s_ff.prot;
      end else if (rsel[2]) begin
        nxt_s.rdata[9:0] = s_ff.div;
      end else if (rsel[3]) begin
        nxt_s.rdata[7:0] = s_ff.prog;
      end else begin
        nxt_s.rresp = nvp_pkg::RESP_DECERR;
      end
    end

    // sequencer
    case (s_ff.st)
      nvp_pkg::ST_IDLE: begin
        if (s_ff.prog[nvp_pkg::PRG_PGM] && s_ff.prog[nvp_pkg::PRG_LAT] && s_ff.div != 10'h000) begin
          nxt_s.tcnt = 9'h000;
          nxt_s.st = prot_hit(s_ff) ? nvp_pkg::ST_HOLD : nvp_pkg::ST_RUN;
        end
      end
      nvp_pkg::ST_RUN: begin
        if (!s_ff.prog[nvp_pkg::PRG_PGM]) begin
          nxt_s.st = nvp_pkg::ST_IDLE;
        end else if (clk_stop) begin
          // wait with clock stopped ends the cycle unsuccessfully
          nxt_s.st = nvp_pkg::ST_HOLD;
        end else if (tick) begin
          if (s_ff.tcnt == nvp_pkg::PGM_TICKS - 9'h001) begin
            if (s_ff.prog[nvp_pkg::PRG_AUTO]) begin
              nxt_s.prog[nvp_pkg::PRG_PGM] = 1'b0;
              nxt_s.st = nvp_pkg::ST_IDLE;
            end else begin
              nxt_s.st = nvp_pkg::ST_HOLD;
            end
          end else begin
            nxt_s.tcnt = s_ff.tcnt + 9'h001;
          end
        end
      end
      nvp_pkg::ST_HOLD: begin
        // waits for software to drop the enable
        if (!s_ff.prog[nvp_pkg::PRG_PGM]) begin
          nxt_s.st = nvp_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_s.st = nvp_pkg::ST_IDLE;
      end
    endcase

    // array writes latched only before enable
    if (arr_wr.wr && s_ff.prog[nvp_pkg::PRG_LAT] && !s_ff.prog[nvp_pkg::PRG_PGM]) begin
      nxt_s.la = arr_wr.addr;
      nxt_s.ld = arr_wr.data;
      nxt_s.lw = arr_wr.word;
    end

    // register writes
    if (wr_go) begin
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = nvp_pkg::RESP_OKAY;
      if (wsel[0]) begin
        if (axi_req.wstrb[0]) begin
          if (special) begin
            // lockout and shadow disable in special mode only
            nxt_s.mcr[nvp_pkg::MCR_DLD] = wd0[nvp_pkg::MCR_DLD];
            nxt_s.mcr[nvp_pkg::MCR_SHD] = wd0[nvp_pkg::MCR_SHD];
            nxt_s.mcr[nvp_pkg::MCR_FO] = wd0[nvp_pkg::MCR_FO];
            nxt_s.mcr[nvp_pkg::MCR_PL] = wd0[nvp_pkg::MCR_PL];
          end else begin
            // normal mode may only close the flash
            if (!wd0[nvp_pkg::MCR_FO]) begin
              nxt_s.mcr[nvp_pkg::MCR_FO] = 1'b0;
            end
            // lock written once in normal mode
            if (!s_ff.lock_once) begin
              nxt_s.mcr[nvp_pkg::MCR_PL] = wd0[nvp_pkg::MCR_PL];
              nxt_s.lock_once = 1'b1;
            end
          end
          nxt_s.mcr[nvp_pkg::MCR_WS] = wd0[nvp_pkg::MCR_WS];
          nxt_s.mcr[nvp_pkg::MCR_DMY] = wd0[nvp_pkg::MCR_DMY];
        end
      end else if (wsel[1]) begin
        if (axi_req.wstrb[0] && !s_ff.mcr[nvp_pkg::MCR_PL]) begin
          nxt_s.prot = wd0[5:0];
        end
      end else if (wsel[2]) begin
        // write once in normal, any time in special, never while latched
        if (!s_ff.prog[nvp_pkg::PRG_LAT] && (special || !s_ff.div_once)) begin
          if (axi_req.wstrb[0]) begin
            nxt_s.div[7:0] = wd0;
          end
          if (axi_req.wstrb[1]) begin
            nxt_s.div[9:8] = wd1[1:0];
          end
          nxt_s.div_once = !special || s_ff.div_once;
        end
      end else if (wsel[3]) begin
        if (axi_req.wstrb[0]) begin
          if (!s_ff.prog[nvp_pkg::PRG_PGM]) begin
            if (!s_ff.mcr[nvp_pkg::MCR_PL]) begin
              nxt_s.prog[nvp_pkg::PRG_BULK_PROTECT] = wd0[nvp_pkg::PRG_BULK_PROTECT];
            end
            nxt_s.prog[nvp_pkg::PRG_AUTO] = wd0[nvp_pkg::PRG_AUTO];
            nxt_s.prog[nvp_pkg::PRG_BYTE] = wd0[nvp_pkg::PRG_BYTE];
            nxt_s.prog[nvp_pkg::PRG_ROW] = wd0[nvp_pkg::PRG_ROW];
            nxt_s.prog[nvp_pkg::PRG_ERASE] = wd0[nvp_pkg::PRG_ERASE];
            if (s_ff.div != 10'h000) begin
              nxt_s.prog[nvp_pkg::PRG_LAT] = wd0[nvp_pkg::PRG_LAT];
            end
          end
          // enable only on an already set latch
          if (!wd0[nvp_pkg::PRG_PGM]) begin
            nxt_s.prog[nvp_pkg::PRG_PGM] = 1'b0;
          end else if (s_ff.prog[nvp_pkg::PRG_LAT]) begin
            nxt_s.prog[nvp_pkg::PRG_PGM] = 1'b1;
          end
        end
      end else begin
        nxt_s.bresp = nvp_pkg::RESP_DECERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_ff <= '0;
      s_ff.st <= nvp_pkg::ST_IDLE;
      // upper nibble from shadow, divider from shadow
      s_ff.mcr <= {shadow_word[15:12], nvp_pkg::MCR_RST_LO};
      s_ff.div <= shadow_word[9:0];
      s_ff.prog <= nvp_pkg::PROG_RST;
      s_ff.prot <= nvp_pkg::PROT_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  nvp_tick u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .run(s_ff.st == nvp_pkg::ST_RUN),
    .div(s_ff.div),
    .tick(tick)
  );

  assign axi_rsp.awready = wr_go;
  assign axi_rsp.wready = wr_go;
  assign axi_rsp.bvalid = s_ff.bvalid;
  assign axi_rsp.bresp = s_ff.bresp;
  assign axi_rsp.arready = rd_go;
  assign axi_rsp.rvalid = s_ff.rvalid;
  assign axi_rsp.rdata = s_ff.rdata;
  assign axi_rsp.rresp = s_ff.rresp;

  // shadow replaces array bytes when enabled
  assign rd_shadow_sel = !s_ff.mcr[nvp_pkg::MCR_SHD] && is_shadow(rd_addr);

  assign nv_op.hv_on = (s_ff.st == nvp_pkg::ST_RUN);
  assign nv_op.erase = s_ff.prog[nvp_pkg::PRG_ERASE];
  assign nv_op.byte_sel = s_ff.prog[nvp_pkg::PRG_BYTE];
  assign nv_op.row_sel = s_ff.prog[nvp_pkg::PRG_ROW];
  // bulk reaches shadow only when enabled
  assign nv_op.bulk_shadow = !s_ff.mcr[nvp_pkg::MCR_SHD];
  assign nv_op.shadow_tgt = !s_ff.mcr[nvp_pkg::MCR_SHD] && is_shadow(s_ff.la);
  assign nv_op.addr = s_ff.la;
  assign nv_op.data = s_ff.ld;
  assign nv_op.word = s_ff.lw;

  assign debug_lockout_disable = s_ff.mcr[nvp_pkg::MCR_DLD];
  assign flash_open = s_ff.mcr[nvp_pkg::MCR_FO];
  // clock stops in wait only when enabled
  assign clk_stop = wait_mode && s_ff.mcr[nvp_pkg::MCR_WS];
endmodule

// ### testbench/nvp_ctrl_asserts.sv
/*
  Port checker for the program/erase control block.
  Assumes one clock; attached by the bind at the foot.
*/
`timescale 1ns/100ps
module nvp_ctrl_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire nvp_pkg::nvp_axi_req_t axi_req,
  input wire nvp_pkg::nvp_axi_rsp_t axi_rsp,
  // chip state and array
  input wire logic special_mode_n,
  input wire logic wait_mode,
  input wire logic [15:0] shadow_word,
  input wire nvp_pkg::nvp_arr_wr_t arr_wr,
  input wire logic [9:0] rd_addr,
  input wire logic rd_shadow_sel,
  input wire nvp_pkg::nvp_nv_op_t nv_op,
  // configuration outputs
  input wire logic debug_lockout_disable,
  input wire logic flash_open,
  input wire logic clk_stop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_take;
    axi_req.awvalid && axi_req.wvalid && !axi_rsp.bvalid;
  endsequence
  sequence s_rd_take;
    axi_req.arvalid && !axi_rsp.rvalid;
  endsequence
  AST_WR_READY: assert property (axi_rsp.awready |-> axi_req.awvalid && axi_req.wvalid && axi_rsp.wready)
    else $error("write taken without both channels");
  AST_WR_ANS: assert property (s_wr_take |=> axi_rsp.bvalid)
    else $error("write not answered");
  AST_B_DONE: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write answer stuck");
  AST_RD_ANS: assert property (s_rd_take |-> axi_rsp.arready ##1 axi_rsp.rvalid)
    else $error("read not answered");
  AST_R_DONE: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
    else $error("read answer stuck");
  // reset must load even while held, so no disable here
  AST_RST_LOAD: assert property (disable iff (1'b0) !rst_b |=>
    flash_open == $past(shadow_word[12]) && debug_lockout_disable == $past(shadow_word[15]))
    else $error("shadow not loaded at reset");
  AST_CLK_STOP: assert property (clk_stop |-> wait_mode)
    else $error("clock stopped outside wait");
  AST_SHADOW_SEL: assert property (rd_shadow_sel |-> rd_addr[9:1] == 9'h1E0)
    else $error("shadow selected off its address");
  AST_ARR_HOLD: assert property (nv_op.hv_on && arr_wr.wr |=> $stable(nv_op.addr) && $stable(nv_op.data))
    else $error("latched target changed in cycle");
  AST_CTRL_FREEZE: assert property (nv_op.hv_on && $past(nv_op.hv_on) |->
    $stable({nv_op.erase, nv_op.byte_sel, nv_op.row_sel}))
    else $error("control bits changed in cycle");
endmodule

bind nvp_ctrl nvp_ctrl_chk u_chk (.clk, .rst_b, .axi_req, .axi_rsp, .special_mode_n, .wait_mode,
  .shadow_word, .arr_wr, .rd_addr, .rd_shadow_sel, .nv_op, .debug_lockout_disable, .flash_open,
  .clk_stop);

// ### testbench/tb_top.sv
/*
  Self-checking bench for the program/erase control block.
  Assumes nvp_pkg and the bound checker are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
  logic clk, rst_b, special_mode_n, wait_mode, rd_shadow_sel;
  logic debug_lockout_disable, flash_open, clk_stop;
  logic [15:0] shadow_word, td;
  logic [9:0] rd_addr, ta;
  logic [1:0] rr;
  logic [7:0] mcr;
  nvp_pkg::nvp_axi_req_t req;
  nvp_pkg::nvp_axi_rsp_t rsp;
  nvp_pkg::nvp_arr_wr_t aw;
  nvp_pkg::nvp_nv_op_t op;
  int miscompares, n_checks, seed, cnt;

  nvp_ctrl u_dut (.clk, .rst_b, .axi_req(req), .axi_rsp(rsp), .special_mode_n, .wait_mode,
    .shadow_word, .arr_wr(aw), .rd_addr, .rd_shadow_sel, .nv_op(op), .debug_lockout_disable,
    .flash_open, .clk_stop);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // bready and rready stay high, so no double drive between transfers
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= s;
    do @(posedge clk); while (rsp.awready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
  endtask

  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    rr = rsp.rresp;
    chk(rsp.rdata, exp);
  endtask

  task automatic arr(input logic [9:0] a, input logic [15:0] d);
    aw <= '{wr: 1'b1, addr: a, data: d, word: 1'b0};
    @(posedge clk);
    aw.wr <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic exp_sel(input logic [9:0] a);
    return a[9:1] == nvp_pkg::SHADOW_ADR[9:1];
  endfunction

  function automatic logic [9:0] exp_div(input int hz);
    return 10'((hz / 1000 * 35 + 500) / 1000);
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial begin
    seed = 39;
    rst_b = 1'b0;
    special_mode_n = 1'b0;
    wait_mode = 1'b0;
    rd_addr = 10'h000;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    aw = '0;
    // shadow word enabled, divider never zero
    shadow_word = 16'(($random(seed) & 32'h0000BFFF) | 32'h1);
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_reg(nvp_pkg::ADR_MCR, {24'h0, shadow_word[15:12], nvp_pkg::MCR_RST_LO});
    rd_reg(nvp_pkg::ADR_DIV, {22'h0, shadow_word[9:0]});
    rd_reg(nvp_pkg::ADR_PROG, {24'h0, nvp_pkg::PROG_RST});
    chk(op.bulk_shadow, 1'b1);
    rd_reg(12'h3D0, 32'h0);
    chk(rr, nvp_pkg::RESP_DECERR);
    wr(nvp_pkg::ADR_MCR, 32'h95);
    mcr = {2'b10, shadow_word[13], 5'b11101};
    rd_reg(nvp_pkg::ADR_MCR, mcr);
    wait_mode <= 1'b1;
    @(posedge clk);
    chk(clk_stop, 1'b1);
    wait_mode <= 1'b0;
    wr(nvp_pkg::ADR_PROT, 32'h01);
    rd_reg(nvp_pkg::ADR_PROT, 32'h01);
    special_mode_n <= 1'b1;
    wr(nvp_pkg::ADR_DIV, {22'h0, exp_div(20000000)}, 4'h3);
    wr(nvp_pkg::ADR_DIV, 32'h005, 4'h3);
    rd_reg(nvp_pkg::ADR_DIV, {22'h0, exp_div(20000000)});
    wr(nvp_pkg::ADR_MCR, 32'h02);
    chk(debug_lockout_disable, 1'b1);
    chk(flash_open, 1'b0);
    wr(nvp_pkg::ADR_MCR, 32'h12);
    mcr = {2'b10, shadow_word[13], 5'b01010};
    rd_reg(nvp_pkg::ADR_MCR, mcr);
    wr(nvp_pkg::ADR_PROT, 32'h00);
    rd_reg(nvp_pkg::ADR_PROT, 32'h01);
    wait_mode <= 1'b1;
    @(posedge clk);
    chk(clk_stop, 1'b0);
    wait_mode <= 1'b0;
    // timed cycle shortened in special mode
    special_mode_n <= 1'b0;
    wr(nvp_pkg::ADR_DIV, 32'h002, 4'h3);
    rd_reg(nvp_pkg::ADR_DIV, 32'h002);
    wr(nvp_pkg::ADR_PROG, 32'h23);
    rd_reg(nvp_pkg::ADR_PROG, 32'hA2);
    ta = 10'($random(seed)) & 10'h1FF;
    td = 16'($random(seed));
    arr(ta, td);
    chk(op.addr, ta);
    chk(op.data, td);
    wr(nvp_pkg::ADR_PROG, 32'h23);
    cnt = 0;
    while (op.hv_on !== 1'b1 && cnt < 10) begin
      @(posedge clk);
      cnt++;
    end
    chk(op.hv_on, 1'b1);
    arr(ta ^ 10'h0FF, ~td);
    chk(op.addr, ta);
    wr(nvp_pkg::ADR_PROG, 32'h27);
    rd_reg(nvp_pkg::ADR_PROG, 32'hA3);
    cnt = 0;
    while (op.hv_on === 1'b1 && cnt < 2000) begin
      @(posedge clk);
      cnt++;
    end
    // 286 ticks of two clocks, less the time spent above
    chk(cnt > 530 && cnt < 580, 1'b1);
    rd_reg(nvp_pkg::ADR_PROG, 32'hA2);
    arr(10'h3D0, td);
    wr(nvp_pkg::ADR_PROG, 32'h23);
    repeat (20) @(posedge clk);
    chk(op.hv_on, 1'b0);
    rd_reg(nvp_pkg::ADR_PROG, 32'hA3);
    wr(nvp_pkg::ADR_PROG, 32'h22);
    wr(nvp_pkg::ADR_PROG, 32'h20);
    rd_reg(nvp_pkg::ADR_PROG, 32'hA0);
    for (int i = 0; i < 8; i++) begin
      ta = (i < 3) ? 10'h3C0 + 10'(i) : 10'($random(seed));
      rd_addr <= ta;
      @(posedge clk);
      chk(rd_shadow_sel, exp_sel(ta));
    end
    special_mode_n <= 1'b0;
    wr(nvp_pkg::ADR_PROG, 32'h26);
    arr(10'h3C1, td);
    chk(op.shadow_tgt, 1'b1);
    chk({op.erase, op.byte_sel, op.row_sel}, 3'b100);
    wr(nvp_pkg::ADR_PROG, 32'h27);
    rd_reg(nvp_pkg::ADR_PROG, 32'hA7);
    chk(op.hv_on, 1'b0);
    wr(nvp_pkg::ADR_PROG, 32'h26);
    wr(nvp_pkg::ADR_PROG, 32'h20);
    wr(nvp_pkg::ADR_MCR, 32'hC2);
    chk(op.bulk_shadow, 1'b0);
    chk(op.shadow_tgt, 1'b0);
    rd_addr <= 10'h3C0;
    @(posedge clk);
    chk(rd_shadow_sel, 1'b0);
    wr(nvp_pkg::ADR_DIV, 32'h000, 4'h3);
    rd_reg(nvp_pkg::ADR_DIV, 32'h000);
    wr(nvp_pkg::ADR_PROG, 32'h22);
    rd_reg(nvp_pkg::ADR_PROG, 32'hA0);
    wr(nvp_pkg::ADR_PROG, 32'h23);
    repeat (10) @(posedge clk);
    chk(op.hv_on, 1'b0);
    complete_run();
  end
endmodule
